// *** iep_cpu_model.sv ***
// Processor core model that acknowledges granted requests and logs them
`timescale 1ns/1ps
`default_nettype none

module iep_cpu_model
	import iep_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// Request from the block
	input  wire logic               cpuReqValid,
	input  wire logic [1:0]         cpuReqLevel,
	input  wire logic [4:0]         cpuReqIndex,
	// Response speed
	input  wire logic [3:0]         ackDelay,
	// Acknowledge and log
	output logic                    cpuAck,
	output logic      [3:0]         ackCnt,
	output iep_cpu_req_t [3:0]      ackLog
);
	int waitCnt;

	// Ack after ackDelay cycles; after an ack skip two edges, the first of which still sees the stale grant
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cpuAck <= 1'b0;
			waitCnt <= 0;
			ackCnt <= 4'h0;
			ackLog <= '0;
		end else begin
			cpuAck <= 1'b0;
			if (cpuAck)
				waitCnt <= -2;
			else if (waitCnt < 0)
				waitCnt <= waitCnt + 1;
			else if (!cpuReqValid)
				waitCnt <= 0;
			else if (waitCnt == int'(ackDelay)) begin
				cpuAck <= 1'b1;
				ackCnt <= ackCnt + 4'h1;
				ackLog[ackCnt[1:0]] <= '{1'b1, iep_level_t'(cpuReqLevel), cpuReqIndex};
			end else
				waitCnt <= waitCnt + 1;
		end
	end
endmodule : iep_cpu_model

`default_nettype wire

// *** iep_defs.svh ***
// Register offsets, field positions, write masks and reset values of the interrupt enable block
`ifndef IEP_DEFS_SVH
`define IEP_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define IEP_OFS_GROUP0_REQ       12'hfc0
`define IEP_OFS_GROUP0_EN_HIGH   12'hfc1
`define IEP_OFS_GROUP0_EN_LOW    12'hfc2
`define IEP_OFS_PORTA_REQ        12'hfc3
`define IEP_OFS_PORTA_EN_HIGH    12'hfc4
`define IEP_OFS_PORTA_EN_LOW     12'hfc5
`define IEP_OFS_PORTC_REQ        12'hfc6
`define IEP_OFS_PORTC_EN_HIGH    12'hfc7
`define IEP_OFS_PORTC_EN_LOW     12'hfc8
`define IEP_OFS_PIN_EDGE_SELECT  12'hfcd
`define IEP_OFS_SHARED_SELECT    12'hfce
`define IEP_OFS_PORT_SELECT      12'hfd0
`define IEP_OFS_EVENT_STATUS     12'hfd1
`define IEP_OFS_EVENT_MASK       12'hfd2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IEP_BIT_TIMER_B          6
`define IEP_BIT_TIMER_A          5
`define IEP_BIT_CONVERTER        0
`define IEP_BIT_COMPARATOR_ROUTE 6
`define IEP_BIT_SHARED_PIN       6
`define IEP_EVT_GROUP0           0
`define IEP_EVT_PORTA            1
`define IEP_EVT_PORTC            2
`define IEP_EVT_UNSAFE_SWITCH    3

// ----------------------------------------------------------------
// Writable bits and reset values
// ----------------------------------------------------------------
`define IEP_MASK_GROUP0          8'h61
`define IEP_MASK_PORTA           8'hff
`define IEP_MASK_PORTC           8'h0f
`define IEP_MASK_SHARED          8'h40
`define IEP_MASK_EVENT           8'h0f
`define IEP_RESET_BYTE           8'h00
`define IEP_RESET_LINES          15'h0000

`endif

// *** iep_edge_detect.sv ***
// Edge detector with per-bit polarity select for pin requests
`timescale 1ns/1ps
`default_nettype none
`include "iep_defs.svh"

module iep_edge_detect
	import iep_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Levels and polarity
	input  wire logic [7:0] level,
	input  wire logic [7:0] riseSel,
	// One-cycle request pulses
	output logic      [7:0] pulse
);

	logic [7:0] prev_ff;

	// Previous level, cleared by reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prev_ff <= `IEP_RESET_BYTE;
		end else begin
			prev_ff <= level;
		end
	end

	// RULE5 polarity per pin
	assign pulse = (riseSel & level & ~prev_ff) | (~riseSel & ~level & prev_ff);

endmodule : iep_edge_detect
`default_nettype wire

// *** iep_irq_enable_priority.sv ***
// Interrupt enable, priority, edge and shared-source selection with request latches
`timescale 1ns/1ps
`default_nettype none
`include "iep_defs.svh"

// Notes on behaviour
// RULE1 - Enable pair codes off, level 1, 2, 3
// RULE2 - Group0 pair: timer B, timer A, converter
// RULE3 - Port A pair: one bit per pin
// RULE4 - Port C pair: pins 3..0, upper reserved
// RULE5 - Edge bit: 0 falling, 1 rising
// RULE6 - Pin source is port A or D
// RULE7 - Route bit picks pin 6 or comparator
// RULE8 - Source switch may itself latch a request
// RULE9 - Software disables shared line before switching
// RULE10 - Reset clears every enable and select register
// RULE11 - Request bit holds until acknowledge or cleared
// RULE12 - Higher level wins, fixed order within level
// RULE13 - Source requests are one-cycle pulses

module iep_irq_enable_priority
	import iep_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Register port
	input  wire logic [11:0] regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [7:0]  regRdata,
	// Request sources
	input  wire logic        timerAPulse,
	input  wire logic        timerBPulse,
	input  wire logic        converterPulse,
	input  wire logic [3:0]  portCPulse,
	input  wire logic [7:0]  portAPins,
	input  wire logic [7:0]  portDPins,
	input  wire logic        comparatorOut,
	// Processor core side
	output logic             cpuReqValid,
	output logic      [1:0]  cpuReqLevel,
	output logic      [4:0]  cpuReqIndex,
	input  wire logic        cpuAck,
	// Block interrupt
	output logic             irqOut
);

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	iep_reg_req_t regReq;
	assign regReq = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

	// Write strobe for one offset
	function automatic logic wr_hit(input iep_reg_req_t r, input logic [11:0] ofs);
		wr_hit = r.wr && (r.addr == ofs);
	endfunction : wr_hit

	wire wrG0Req   = wr_hit(regReq, `IEP_OFS_GROUP0_REQ);
	wire wrG0High  = wr_hit(regReq, `IEP_OFS_GROUP0_EN_HIGH);
	wire wrG0Low   = wr_hit(regReq, `IEP_OFS_GROUP0_EN_LOW);
	wire wrPaReq   = wr_hit(regReq, `IEP_OFS_PORTA_REQ);
	wire wrPaHigh  = wr_hit(regReq, `IEP_OFS_PORTA_EN_HIGH);
	wire wrPaLow   = wr_hit(regReq, `IEP_OFS_PORTA_EN_LOW);
	wire wrPcReq   = wr_hit(regReq, `IEP_OFS_PORTC_REQ);
	wire wrPcHigh  = wr_hit(regReq, `IEP_OFS_PORTC_EN_HIGH);
	wire wrPcLow   = wr_hit(regReq, `IEP_OFS_PORTC_EN_LOW);
	wire wrEdge    = wr_hit(regReq, `IEP_OFS_PIN_EDGE_SELECT);
	wire wrShared  = wr_hit(regReq, `IEP_OFS_SHARED_SELECT);
	wire wrPortSel = wr_hit(regReq, `IEP_OFS_PORT_SELECT);
	wire wrStatus  = wr_hit(regReq, `IEP_OFS_EVENT_STATUS);
	wire wrMask    = wr_hit(regReq, `IEP_OFS_EVENT_MASK);

	// ----------------------------------------------------------------
	// Enable, select and mask registers
	// ----------------------------------------------------------------
	logic [7:0] group0EnableHigh_ff;
	logic [7:0] group0EnableLow_ff;
	logic [7:0] portaEnableHigh_ff;
	logic [7:0] portaEnableLow_ff;
	logic [7:0] portcEnableHigh_ff;
	logic [7:0] portcEnableLow_ff;
	logic [7:0] pinEdgeSelect_ff;
	logic [7:0] sharedSourceSelect_ff;
	logic [7:0] portSelect_ff;
	logic [7:0] eventMask_ff;

	// RULE2 group0 reserved bits stay zero
	wire [7:0] nxt_group0EnableHigh = wrG0High ? (regWdata & `IEP_MASK_GROUP0) : group0EnableHigh_ff;
	wire [7:0] nxt_group0EnableLow  = wrG0Low  ? (regWdata & `IEP_MASK_GROUP0) : group0EnableLow_ff;
	// RULE3 full port A byte
	wire [7:0] nxt_portaEnableHigh  = wrPaHigh ? (regWdata & `IEP_MASK_PORTA)  : portaEnableHigh_ff;
	wire [7:0] nxt_portaEnableLow   = wrPaLow  ? (regWdata & `IEP_MASK_PORTA)  : portaEnableLow_ff;
	// RULE4 port C low nibble only
	wire [7:0] nxt_portcEnableHigh  = wrPcHigh ? (regWdata & `IEP_MASK_PORTC)  : portcEnableHigh_ff;
	wire [7:0] nxt_portcEnableLow   = wrPcLow  ? (regWdata & `IEP_MASK_PORTC)  : portcEnableLow_ff;
	wire [7:0] nxt_pinEdgeSelect    = wrEdge   ? regWdata : pinEdgeSelect_ff;
	wire [7:0] nxt_sharedSource     = wrShared ? (regWdata & `IEP_MASK_SHARED) : sharedSourceSelect_ff;
	wire [7:0] nxt_portSelect       = wrPortSel ? regWdata : portSelect_ff;
	wire [7:0] nxt_eventMask        = wrMask   ? (regWdata & `IEP_MASK_EVENT)  : eventMask_ff;

	// RULE10 reset clears all settings
	always_ff @(posedge clk) begin
		if (!rstn) begin
			group0EnableHigh_ff   <= `IEP_RESET_BYTE;
			group0EnableLow_ff    <= `IEP_RESET_BYTE;
			portaEnableHigh_ff    <= `IEP_RESET_BYTE;
			portaEnableLow_ff     <= `IEP_RESET_BYTE;
			portcEnableHigh_ff    <= `IEP_RESET_BYTE;
			portcEnableLow_ff     <= `IEP_RESET_BYTE;
			pinEdgeSelect_ff      <= `IEP_RESET_BYTE;
			sharedSourceSelect_ff <= `IEP_RESET_BYTE;
			portSelect_ff         <= `IEP_RESET_BYTE;
			eventMask_ff          <= `IEP_RESET_BYTE;
		end else begin
			group0EnableHigh_ff   <= nxt_group0EnableHigh;
			group0EnableLow_ff    <= nxt_group0EnableLow;
			portaEnableHigh_ff    <= nxt_portaEnableHigh;
			portaEnableLow_ff     <= nxt_portaEnableLow;
			portcEnableHigh_ff    <= nxt_portcEnableHigh;
			portcEnableLow_ff     <= nxt_portcEnableLow;
			pinEdgeSelect_ff      <= nxt_pinEdgeSelect;
			sharedSourceSelect_ff <= nxt_sharedSource;
			portSelect_ff         <= nxt_portSelect;
			eventMask_ff          <= nxt_eventMask;
		end
	end

	// ----------------------------------------------------------------
	// Pin source selection and edge detection
	// ----------------------------------------------------------------
	logic [7:0] pinLevel;
	logic [7:0] pinPulse;

	// RULE6 port A or port D per pin
	wire [7:0] portPinLevel = (portSelect_ff & portDPins) | (~portSelect_ff & portAPins);

	// RULE7 comparator replaces pin 6 when routed
	wire comparatorRoute = sharedSourceSelect_ff[`IEP_BIT_COMPARATOR_ROUTE];
	always_comb begin
		pinLevel = portPinLevel;
		pinLevel[`IEP_BIT_SHARED_PIN] = comparatorRoute ? comparatorOut : portPinLevel[`IEP_BIT_SHARED_PIN];
	end

	// RULE8 edge taken after the mux, so a switch can fire
	iep_edge_detect u_edge (
		.clk     (clk),
		.rstn    (rstn),
		.level   (pinLevel),
		.riseSel (pinEdgeSelect_ff),
		.pulse   (pinPulse)
	);

	// ----------------------------------------------------------------
	// Line vectors: index 0 converter, 1 timer A, 2 timer B,
	// 3..10 port A pins 0..7, 11..14 port C pins 0..3
	// ----------------------------------------------------------------
	// RULE13 every source arrives as a single-cycle pulse
	wire [IEP_NLINES-1:0] srcPulse = {portCPulse, pinPulse, timerBPulse, timerAPulse, converterPulse};

	// RULE1 pair bits gathered per line
	wire [IEP_NLINES-1:0] lineHigh = {portcEnableHigh_ff[3:0], portaEnableHigh_ff,
	                                  group0EnableHigh_ff[`IEP_BIT_TIMER_B],
	                                  group0EnableHigh_ff[`IEP_BIT_TIMER_A],
	                                  group0EnableHigh_ff[`IEP_BIT_CONVERTER]};
	wire [IEP_NLINES-1:0] lineLow  = {portcEnableLow_ff[3:0], portaEnableLow_ff,
	                                  group0EnableLow_ff[`IEP_BIT_TIMER_B],
	                                  group0EnableLow_ff[`IEP_BIT_TIMER_A],
	                                  group0EnableLow_ff[`IEP_BIT_CONVERTER]};

	// ----------------------------------------------------------------
	// Request latches
	// ----------------------------------------------------------------
	logic [IEP_NLINES-1:0] request_ff;
	iep_cpu_req_t          winner;
	iep_cpu_req_t          cpuReq_ff;

	// Software write image of the request registers
	wire [IEP_NLINES-1:0] reqWrMask = {{4{wrPcReq}}, {8{wrPaReq}}, {3{wrG0Req}}};
	wire [IEP_NLINES-1:0] reqWrData = {regWdata[3:0], regWdata,
	                                   regWdata[`IEP_BIT_TIMER_B], regWdata[`IEP_BIT_TIMER_A],
	                                   regWdata[`IEP_BIT_CONVERTER]};
	// Acknowledge clears the line that was offered
	wire [IEP_NLINES-1:0] ackClear  = (cpuAck && cpuReq_ff.valid) ?
	                                  (IEP_NLINES'(1) << cpuReq_ff.index) : '0;

	// RULE11 hold until ack or write; a new pulse wins over both
	wire [IEP_NLINES-1:0] nxt_request = (((request_ff & ~reqWrMask) | (reqWrData & reqWrMask)) & ~ackClear)
	                                    | srcPulse;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			request_ff <= `IEP_RESET_LINES;
		end else begin
			request_ff <= nxt_request;
		end
	end

	// ----------------------------------------------------------------
	// Priority selection toward the processor core
	// ----------------------------------------------------------------
	// RULE12 level first, then lower index
	iep_prio_select u_prio (
		.pending (request_ff),
		.enHigh  (lineHigh),
		.enLow   (lineLow),
		.winner  (winner)
	);

	// Registered offer; cleared line drops out two cycles after ack, one stale cycle in between
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cpuReq_ff <= '0;
		end else begin
			cpuReq_ff <= winner;
		end
	end

	assign cpuReqValid = cpuReq_ff.valid;
	assign cpuReqLevel = cpuReq_ff.level;
	assign cpuReqIndex = cpuReq_ff.index;

	// ----------------------------------------------------------------
	// Block event status and interrupt
	// ----------------------------------------------------------------
	logic [7:0] eventStatus_ff;

	// RULE9 a source switch with the shared line enabled is flagged
	wire sharedLineOn  = portaEnableHigh_ff[`IEP_BIT_SHARED_PIN] | portaEnableLow_ff[`IEP_BIT_SHARED_PIN];
	wire unsafeSwitch  = wrShared && sharedLineOn &&
	                     (nxt_sharedSource[`IEP_BIT_COMPARATOR_ROUTE] != comparatorRoute);

	// Events per group, one cycle each
	wire [7:0] eventSet = {4'h0, unsafeSwitch, |srcPulse[14:11], |srcPulse[10:3], |srcPulse[2:0]};

	// Write one to clear; a same-cycle event keeps its bit
	wire [7:0] nxt_eventStatus = ((eventStatus_ff & ~(wrStatus ? regWdata : 8'h00)) | eventSet)
	                             & `IEP_MASK_EVENT;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			eventStatus_ff <= `IEP_RESET_BYTE;
		end else begin
			eventStatus_ff <= nxt_eventStatus;
		end
	end

	// Level output while any unmasked status bit stands
	assign irqOut = |(eventStatus_ff & eventMask_ff);

	// ----------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------------------------------
	logic [7:0] rdMux;

	// Group0 request image in register bit positions
	wire [7:0] group0ReqImage = {1'b0, request_ff[2], request_ff[1], 4'h0, request_ff[0]};

	always_comb begin
		unique case (regAddr)
			`IEP_OFS_GROUP0_REQ:      rdMux = group0ReqImage;
			`IEP_OFS_GROUP0_EN_HIGH:  rdMux = group0EnableHigh_ff;
			`IEP_OFS_GROUP0_EN_LOW:   rdMux = group0EnableLow_ff;
			`IEP_OFS_PORTA_REQ:       rdMux = request_ff[10:3];
			`IEP_OFS_PORTA_EN_HIGH:   rdMux = portaEnableHigh_ff;
			`IEP_OFS_PORTA_EN_LOW:    rdMux = portaEnableLow_ff;
			`IEP_OFS_PORTC_REQ:       rdMux = {4'h0, request_ff[14:11]};
			`IEP_OFS_PORTC_EN_HIGH:   rdMux = portcEnableHigh_ff;
			`IEP_OFS_PORTC_EN_LOW:    rdMux = portcEnableLow_ff;
			`IEP_OFS_PIN_EDGE_SELECT: rdMux = pinEdgeSelect_ff;
			`IEP_OFS_SHARED_SELECT:   rdMux = sharedSourceSelect_ff;
			`IEP_OFS_PORT_SELECT:     rdMux = portSelect_ff;
			`IEP_OFS_EVENT_STATUS:    rdMux = eventStatus_ff;
			`IEP_OFS_EVENT_MASK:      rdMux = eventMask_ff;
			default:                  rdMux = 8'h00; // Unmapped reads as zero
		endcase
	end

	// Data held only in the cycle after a read strobe
	always_ff @(posedge clk) begin
		if (!rstn) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= regRd ? rdMux : 8'h00;
		end
	end

endmodule : iep_irq_enable_priority
`default_nettype wire

// *** iep_irq_props.sv ***
// Port-level concurrent checks for the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none
`include "iep_defs.svh"

module iep_irq_props
	import iep_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Register port
	input  wire logic [11:0] regAddr,
	input  wire logic        regWr,
	input  wire logic        regRd,
	input  wire logic [7:0]  regRdata,
	// Processor core side
	input  wire logic        cpuReqValid,
	input  wire logic [1:0]  cpuReqLevel,
	input  wire logic [4:0]  cpuReqIndex,
	input  wire logic        cpuAck,
	input  wire logic        irqOut
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	// Core takes a live request
	sequence ackTaken;
		cpuAck && cpuReqValid;
	endsequence
	// Read data of address a stands now
	sequence readDone(logic [11:0] a);
		$past(regRd) && $past(regAddr) == a;
	endsequence

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	reset_outputs_clear_a: assert property ($rose(rstn) |-> !cpuReqValid && !irqOut && regRdata == 8'h00)
		else $error("outputs not clear after reset");
	level_nonzero_a: assert property (cpuReqValid |-> cpuReqLevel != 2'h0)
		else $error("granted request has level off");
	index_in_range_a: assert property (cpuReqValid |-> cpuReqIndex < 5'd15)
		else $error("granted index out of range");
	// Acked line leaves the grant two edges later, stale edge in between
	ack_retires_line_a: assert property (ackTaken |-> ##2 !(cpuReqValid && cpuReqIndex == $past(cpuReqIndex, 2)))
		else $error("acknowledged line still granted");
	// The grant lags the latches by one edge, so an ack or write one edge back may still retire it
	request_holds_a: assert property (cpuReqValid && !$past(cpuAck) && !$past(regWr) |=> cpuReqValid)
		else $error("request dropped without ack or write");
	level_never_drops_a: assert property (cpuReqValid && !$past(cpuAck) && !$past(regWr)
		|=> cpuReqLevel >= $past(cpuReqLevel))
		else $error("granted level fell without ack or write");
	group0_reserved_zero_a: assert property (readDone(`IEP_OFS_GROUP0_EN_HIGH) or readDone(`IEP_OFS_GROUP0_EN_LOW)
		|-> (regRdata & ~`IEP_MASK_GROUP0) == 8'h00)
		else $error("group0 reserved bits read nonzero");
	portc_reserved_zero_a: assert property (readDone(`IEP_OFS_PORTC_EN_HIGH) or readDone(`IEP_OFS_PORTC_EN_LOW)
		|-> regRdata[7:4] == 4'h0)
		else $error("port C upper bits read nonzero");
	shared_reserved_zero_a: assert property (readDone(`IEP_OFS_SHARED_SELECT) |-> (regRdata & ~`IEP_MASK_SHARED) == 8'h00)
		else $error("shared select reserved bits nonzero");
endmodule : iep_irq_props

bind iep_irq_enable_priority iep_irq_props chk_u (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWr(regWr),
	.regRd(regRd), .regRdata(regRdata), .cpuReqValid(cpuReqValid), .cpuReqLevel(cpuReqLevel),
	.cpuReqIndex(cpuReqIndex), .cpuAck(cpuAck), .irqOut(irqOut));

`default_nettype wire

// *** iep_pkg.sv ***
// Types shared by the interrupt enable and priority block
package iep_pkg;

	// Number of request lines: three group0, eight port A, four port C
	localparam int IEP_NLINES = 15;

	// Priority level of one line, from its high and low enable bits
	typedef enum logic [1:0] {
		IEP_LVL_OFF,
		IEP_LVL_1,
		IEP_LVL_2,
		IEP_LVL_3
	} iep_level_t;

	// Request handed to the processor core
	typedef struct packed {
		logic       valid;
		iep_level_t level;
		logic [4:0] index;
	} iep_cpu_req_t;

	// Register port request
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} iep_reg_req_t;

endpackage : iep_pkg

// *** iep_prio_select.sv ***
// Picks the highest-priority pending enabled request line
`timescale 1ns/1ps
`default_nettype none

module iep_prio_select
	import iep_pkg::*;
(
	// Pending requests and enable pairs
	input  wire logic [IEP_NLINES-1:0] pending,
	input  wire logic [IEP_NLINES-1:0] enHigh,
	input  wire logic [IEP_NLINES-1:0] enLow,
	// Winner
	output iep_cpu_req_t               winner
);

	// Level of one line from its enable pair
	function automatic iep_level_t line_level(input logic hi, input logic lo);
		line_level = iep_level_t'({hi, lo});
	endfunction : line_level

	// Walk from the last line to the first so a lower index wins a tie
	always_comb begin
		winner = '0;
		for (int i = IEP_NLINES - 1; i >= 0; i--) begin
			// RULE12 level then order
			if (pending[i] && line_level(enHigh[i], enLow[i]) != IEP_LVL_OFF &&
			    line_level(enHigh[i], enLow[i]) >= winner.level) begin
				winner.valid = 1'b1;
				winner.level = line_level(enHigh[i], enLow[i]);
				winner.index = 5'(i);
			end
		end
	end

endmodule : iep_prio_select
`default_nettype wire

// *** irq_enable_priority_select_test.sv ***
// Self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none
`include "iep_defs.svh"

module irq_enable_priority_select_test
	import iep_pkg::*;
;
	logic clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, timerAPulse = 1'b0, timerBPulse = 1'b0;
	logic converterPulse = 1'b0, comparatorOut = 1'b0, cpuAck, cpuReqValid, irqOut;
	logic [11:0] regAddr = 12'h000;
	logic [7:0]  regWdata = 8'h00, portAPins = 8'h00, portDPins = 8'h00, regRdata;
	logic [3:0]  portCPulse = 4'h0, ackDelay = 4'h3, ackCnt;
	logic [1:0]  cpuReqLevel;
	logic [4:0]  cpuReqIndex;
	iep_cpu_req_t [3:0] ackLog;
	int error_cnt = 0, total_checks = 0;
	// Rows: address, write data, read-back value
	// Port A rows keep bit 6 off in both halves so the later source switch is a safe one
	logic [27:0] rows [9] = '{28'hfc1ff61, 28'hfc2ff61, 28'hfc4a5a5, 28'hfc51a1a, 28'hfc7ff0f,
		28'hfc8ff0f, 28'hfcd3c3c, 28'hfceff40, 28'hfc9ff00};
	iep_cpu_req_t expReq [4] = '{'{1'b1, IEP_LVL_3, 5'd2}, '{1'b1, IEP_LVL_3, 5'd12},
		'{1'b1, IEP_LVL_2, 5'd0}, '{1'b1, IEP_LVL_2, 5'd1}};

	always #2 clk = ~clk;

	iep_irq_enable_priority dut_u (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .timerAPulse(timerAPulse),
		.timerBPulse(timerBPulse), .converterPulse(converterPulse), .portCPulse(portCPulse),
		.portAPins(portAPins), .portDPins(portDPins), .comparatorOut(comparatorOut),
		.cpuReqValid(cpuReqValid), .cpuReqLevel(cpuReqLevel), .cpuReqIndex(cpuReqIndex),
		.cpuAck(cpuAck), .irqOut(irqOut));
	iep_cpu_model cpu_u (.clk(clk), .rstn(rstn), .cpuReqValid(cpuReqValid), .cpuReqLevel(cpuReqLevel),
		.cpuReqIndex(cpuReqIndex), .ackDelay(ackDelay), .cpuAck(cpuAck), .ackCnt(ackCnt), .ackLog(ackLog));

	// ------------------------------------------------------------
	// Compare, bus and stimulus tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chkReq(input iep_cpu_req_t got, input iep_cpu_req_t exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: grant %h expected %h", $time, got, exp);
		end
	endtask : chkReq
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk8(regRdata, e);
	endtask : rdc
	task automatic pins(input logic [7:0] a, input logic [7:0] d, input logic c);
		@(posedge clk);
		portAPins <= a;
		portDPins <= d;
		comparatorOut <= c;
		@(posedge clk);
	endtask : pins
	task automatic waitAck(input logic [3:0] n);
		int k = 0;
		while (ackCnt !== n && k < 200) begin
			@(posedge clk);
			k++;
		end
		if (ackCnt !== n) begin
			error_cnt++;
			$display("wrong value at %0t: acknowledge wait ran out", $time);
			wrap_up();
		end
	endtask : waitAck

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// Reset value, write masks and unmapped place, row by row
		for (int i = 0; i < 9; i++) begin
			rdc(rows[i][27:16], 8'h00);
			wr(rows[i][27:16], rows[i][15:8]);
			rdc(rows[i][27:16], rows[i][7:0]);
		end
		// Same-edge requests at two levels; port C stays at level 3 from the rows
		wr(`IEP_OFS_GROUP0_EN_HIGH, 8'h61);
		wr(`IEP_OFS_GROUP0_EN_LOW, 8'h40);
		wr(`IEP_OFS_PORTA_EN_HIGH, 8'h00);
		wr(`IEP_OFS_PORTA_EN_LOW, 8'h00);
		@(posedge clk);
		timerAPulse <= 1'b1;
		timerBPulse <= 1'b1;
		converterPulse <= 1'b1;
		portCPulse <= 4'h2;
		@(posedge clk);
		timerAPulse <= 1'b0;
		timerBPulse <= 1'b0;
		converterPulse <= 1'b0;
		portCPulse <= 4'h0;
		waitAck(4'h4);
		for (int i = 0; i < 4; i++)
			chkReq(ackLog[i], expReq[i]);
		repeat (3) @(posedge clk);
		chk8({7'h00, cpuReqValid}, 8'h00);
		// Sticky status, mask and write-one-to-clear
		chk8({7'h00, irqOut}, 8'h00);
		rdc(`IEP_OFS_EVENT_STATUS, 8'h05);
		wr(`IEP_OFS_EVENT_MASK, 8'h01);
		#1 chk8({7'h00, irqOut}, 8'h01);
		wr(`IEP_OFS_EVENT_STATUS, 8'h01);
		#1 chk8({7'h00, irqOut}, 8'h00);
		rdc(`IEP_OFS_EVENT_STATUS, 8'h04);
		// Pin 2 rising, pin 3 falling; disabled lines latch but never grant
		wr(`IEP_OFS_PIN_EDGE_SELECT, 8'h04);
		pins(8'h0c, 8'h00, 1'b0);
		pins(8'h00, 8'h00, 1'b0);
		rdc(`IEP_OFS_PORTA_REQ, 8'h0c);
		chk8({7'h00, cpuReqValid}, 8'h00);
		// Pin 4 taken from port D: its port A fall is ignored
		wr(`IEP_OFS_PORTA_REQ, 8'h00);
		wr(`IEP_OFS_PORT_SELECT, 8'h10);
		pins(8'h10, 8'h10, 1'b0);
		pins(8'h00, 8'h10, 1'b0);
		rdc(`IEP_OFS_PORTA_REQ, 8'h00);
		pins(8'h00, 8'h00, 1'b0);
		rdc(`IEP_OFS_PORTA_REQ, 8'h10);
		// Line 6 enables are already off before any source switch
		wr(`IEP_OFS_PORTA_REQ, 8'h00);
		wr(`IEP_OFS_SHARED_SELECT, 8'h00);
		pins(8'h00, 8'h00, 1'b1);
		pins(8'h00, 8'h00, 1'b0);
		rdc(`IEP_OFS_PORTA_REQ, 8'h00);
		pins(8'h00, 8'h00, 1'b1);
		wr(`IEP_OFS_SHARED_SELECT, 8'h40);
		wr(`IEP_OFS_SHARED_SELECT, 8'h00);
		rdc(`IEP_OFS_PORTA_REQ, 8'h40);
		wr(`IEP_OFS_PORTA_REQ, 8'h00);
		wr(`IEP_OFS_SHARED_SELECT, 8'h40);
		pins(8'h00, 8'h00, 1'b0);
		rdc(`IEP_OFS_PORTA_REQ, 8'h40);
		// Switching the source with line 6 enabled raises the unsafe-switch status bit
		wr(`IEP_OFS_PORTA_EN_LOW, 8'h40);
		wr(`IEP_OFS_SHARED_SELECT, 8'h00);
		rdc(`IEP_OFS_EVENT_STATUS, 8'h0e);
		// Second reset in mid-run
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rdc(`IEP_OFS_SHARED_SELECT, 8'h00);
		rdc(`IEP_OFS_PIN_EDGE_SELECT, 8'h00);
		rdc(`IEP_OFS_PORT_SELECT, 8'h00);
		wrap_up();
	end
endmodule : irq_enable_priority_select_test

`default_nettype wire
